/* hw/bdl_pkg.sv */
/*
 Constants, types and helpers shared by the byte/dual load unit.
 Assumes a single core clock and a synchronous active-high reset.
*/
`default_nettype none
package bdl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CLEAR  = 8'h04;
    localparam logic [7:0] ADR_ENABLE = 8'h08;
    localparam logic [7:0] ADR_CTRL   = 8'h0c;
    localparam logic [7:0] ADR_LASTAD = 8'h10;
    localparam logic [7:0] ADR_STATE  = 8'h14;
    localparam logic [1:0] WIN_REGS   = 2'h1;
    // Event bit positions
    localparam int EV_DONE   = 0;
    localparam int EV_PROT   = 1;
    localparam int EV_BUS    = 2;
    localparam int EV_USAGE  = 3;
    localparam int EV_UNPRED = 4;
    localparam int NEV       = 5;
    localparam logic       CTRL_RST   = 1'h1;
    // Encoding patterns
    localparam logic [4:0]  OPC16_IMM  = 5'h0f;
    localparam logic [6:0]  OPC16_REG  = 7'h2e;
    localparam logic [11:0] OPC_LONG_IMMEDIATE  = 12'hf89;
    localparam logic [11:0] OPC_SHORT_IMMEDIATE   = 12'hf81;
    localparam logic [7:0]  OPC_LIT_HI = 8'hf8;
    localparam logic [6:0]  OPC_LIT_LO = 7'h1f;
    localparam logic [6:0]  OPC_DUAL   = 7'h74;
    localparam logic [5:0]  REG_MARK   = 6'h00;
    localparam logic [3:0]  REG_ONES   = 4'hf;
    localparam logic [3:0]  REG_SP     = 4'hd;
    localparam logic [31:0] WORD_STEP  = 32'h4;
    localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;
    localparam logic [1:0]  SIZE_BYTE  = 2'h0;
    localparam logic [1:0]  SIZE_WORD  = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACC1 = 2'h1,
        ST_ACC2 = 2'h3
    } bdl_state_t;

    typedef enum logic [2:0] {
        OP_UNSUP  = 3'h0,
        OP_BYTE   = 3'h1,
        OP_UNPRIV = 3'h2,
        OP_DUAL   = 3'h3,
        OP_HINT   = 3'h4,
        OP_UNDEF  = 3'h5
    } bdl_op_t;

    // Stack pointer or program counter
    function automatic logic sp_or_pc(input logic [3:0] r);
        return (r == REG_SP) || (r == REG_ONES);
    endfunction

    // Byte-lane merge of a bus write
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

/* hw/bdl_dec_if.sv */
/*
 Carrier between the load unit and its instruction decoder.
 Assumes the decoder is purely combinational.
*/
`default_nettype none
interface bdl_dec_if;
    logic [31:0]      instr;
    logic             wide;
    bdl_pkg::bdl_op_t op;
    logic [3:0]       rt;
    logic [3:0]       rt2;
    logic [3:0]       rn;
    logic [3:0]       rm;
    logic [31:0]      imm;
    logic [1:0]       shift;
    logic             index;
    logic             add;
    logic             wback;
    logic             literal;
    logic             regofs;
    logic             unpred;

    modport dec (input instr, wide, output op, rt, rt2, rn, rm, imm, shift,
                 index, add, wback, literal, regofs, unpred);
    modport use_side (output instr, wide, input op, rt, rt2, rn, rm, imm, shift,
                      index, add, wback, literal, regofs, unpred);
endinterface
`default_nettype wire

/* hw/bdl_decode.sv */
/*
 Combinational decoder for byte and dual loads.
 Assumes short encodings sit in instr[15:0] and wide ones as {first, second}.
*/
`default_nettype none
module bdl_decode (
    bdl_dec_if.dec d
);
    logic [15:0] h1;
    logic [15:0] h2;

    assign h1 = d.wide ? d.instr[31:16] : d.instr[15:0];
    assign h2 = d.instr[15:0];

    // Field extraction and classification
    always_comb begin
        d.op = bdl_pkg::OP_UNSUP;
        d.rt = '0;
        d.rt2 = '0;
        d.rn = '0;
        d.rm = '0;
        d.imm = '0;
        d.shift = '0;
        d.index = 1'b1;
        d.add = 1'b1;
        d.wback = 1'b0;
        d.literal = 1'b0;
        d.regofs = 1'b0;
        d.unpred = 1'b0;
        if (!d.wide) begin
            d.rn = {1'b0, h1[5:3]};
            d.rt = {1'b0, h1[2:0]};
            d.rm = {1'b0, h1[8:6]};
            if (h1[15:11] == bdl_pkg::OPC16_IMM) begin
                d.op = bdl_pkg::OP_BYTE;
                d.imm = {27'h0, h1[10:6]};
            end else if (h1[15:9] == bdl_pkg::OPC16_REG) begin
                d.op = bdl_pkg::OP_BYTE;
                d.regofs = 1'b1;
            end
        end else if (h1[15:8] == bdl_pkg::OPC_LIT_HI && h1[6:0] == bdl_pkg::OPC_LIT_LO) begin
            // Base all ones lands here from every byte form
            d.rt = h2[15:12];
            d.literal = 1'b1;
            d.add = h1[7];
            d.imm = {20'h0, h2[11:0]};
            d.op = (d.rt == bdl_pkg::REG_ONES) ? bdl_pkg::OP_HINT : bdl_pkg::OP_BYTE;
            d.unpred = (d.rt == bdl_pkg::REG_SP);
        end else if (h1[15:4] == bdl_pkg::OPC_LONG_IMMEDIATE) begin
            d.rn = h1[3:0];
            d.rt = h2[15:12];
            d.imm = {20'h0, h2[11:0]};
            d.op = (d.rt == bdl_pkg::REG_ONES) ? bdl_pkg::OP_HINT : bdl_pkg::OP_BYTE;
            d.unpred = (d.rt == bdl_pkg::REG_SP);
        end else if (h1[15:4] == bdl_pkg::OPC_SHORT_IMMEDIATE) begin
            d.rn = h1[3:0];
            d.rt = h2[15:12];
            d.rm = h2[3:0];
            if (h2[11]) begin
                d.imm = {24'h0, h2[7:0]};
                d.index = h2[10];
                d.add = h2[9];
                d.wback = h2[8];
                if (d.rt == bdl_pkg::REG_ONES && h2[10:8] == 3'h4) begin
                    d.op = bdl_pkg::OP_HINT;
                end else if (h2[10:8] == 3'h6) begin
                    d.op = bdl_pkg::OP_UNPRIV;
                    d.wback = 1'b0;
                    d.unpred = bdl_pkg::sp_or_pc(d.rt);
                end else if (!h2[10] && !h2[8]) begin
                    d.op = bdl_pkg::OP_UNDEF;
                end else begin
                    d.op = bdl_pkg::OP_BYTE;
                    d.unpred = (d.rt == bdl_pkg::REG_SP) || (d.wback && d.rn == d.rt)
                             || (d.rt == bdl_pkg::REG_ONES);
                end
            end else if (h2[11:6] == bdl_pkg::REG_MARK) begin
                d.regofs = 1'b1;
                d.shift = h2[5:4];
                d.op = (d.rt == bdl_pkg::REG_ONES) ? bdl_pkg::OP_HINT : bdl_pkg::OP_BYTE;
                d.unpred = (d.rt == bdl_pkg::REG_SP) || bdl_pkg::sp_or_pc(d.rm);
            end else begin
                d.op = bdl_pkg::OP_UNDEF;
            end
        end else if (h1[15:9] == bdl_pkg::OPC_DUAL && h1[6] && h1[4]) begin
            d.rn = h1[3:0];
            d.rt = h2[15:12];
            d.rt2 = h2[11:8];
            d.index = h1[8];
            d.add = h1[7];
            d.wback = h1[5];
            d.imm = {22'h0, h2[7:0], 2'h0};
            if ((!h1[8] && !h1[5]) || d.rn == bdl_pkg::REG_ONES) begin
                d.op = bdl_pkg::OP_UNSUP;
            end else begin
                d.op = bdl_pkg::OP_DUAL;
                d.unpred = (d.wback && (d.rn == d.rt || d.rn == d.rt2))
                         || bdl_pkg::sp_or_pc(d.rt) || bdl_pkg::sp_or_pc(d.rt2)
                         || (d.rt == d.rt2);
            end
        end
    end
endmodule
`default_nettype wire

/* hw/bdl_unit.sv */
/*
 Byte-load and dual-word-load execution unit with its own register file,
 a classic Wishbone slave for control and register access, and a
 memory request port.
 Assumes instruction, memory and bus inputs share clock_in.
*/
`default_nettype none
module bdl_unit (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    // Instruction side
    input  wire logic        instr_valid_in,
    input  wire logic [31:0] instr_in,
    input  wire logic        instr_wide_in,
    input  wire logic        cond_pass_in,
    input  wire logic [31:0] pc_in,
    output logic             instr_ready_out,
    output logic             done_out,
    // Memory side
    output logic             mem_req_out,
    output logic      [31:0] mem_addr_out,
    output logic      [1:0]  mem_size_out,
    output logic             mem_unpriv_out,
    input  wire logic [31:0] mem_rdata_in,
    input  wire logic        mem_ack_in,
    input  wire logic        mem_err_in,
    input  wire logic        mem_prot_in
);
    typedef struct packed {
        bdl_pkg::bdl_state_t     st;
        logic [31:0]             addr;
        logic [31:0]             wb_val;
        logic [3:0]              rt;
        logic [3:0]              rt2;
        logic [3:0]              rn;
        logic                    wback;
        logic                    dual;
        logic                    unpriv;
        logic [31:0]             word1;
        logic [15:0][31:0]       regs;
        logic [bdl_pkg::NEV-1:0] status;
        logic [bdl_pkg::NEV-1:0] enable;
        logic                    ctrl_en;
        logic [31:0]             last_addr;
        logic                    ack;
        logic [31:0]             rdata;
        logic                    done;
    } bdl_core_t;

    bdl_core_t q;
    bdl_core_t n;

    logic [31:0]             base_v;
    logic [31:0]             ofs_v;
    logic [31:0]             oadr_v;
    logic [31:0]             madr_v;
    logic                    bus_req;
    logic                    is_win;
    logic [3:0]              win_idx;
    logic [bdl_pkg::NEV-1:0] ev;
    logic [bdl_pkg::NEV-1:0] clr;
    logic                    take;

    bdl_dec_if dif ();

    assign dif.instr = instr_in;
    assign dif.wide  = instr_wide_in;

    bdl_decode u_dec (
        .d (dif.dec)
    );

    // Address formation
    assign base_v = dif.literal ? (pc_in & bdl_pkg::ALIGN_MASK) : q.regs[dif.rn];
    assign ofs_v  = dif.regofs ? (q.regs[dif.rm] << dif.shift) : dif.imm;
    assign oadr_v = dif.add ? (base_v + ofs_v) : (base_v - ofs_v);
    assign madr_v = dif.index ? oadr_v : base_v;

    // Bus decode
    assign bus_req = wb_cyc_in && wb_stb_in && !q.ack;
    assign is_win  = (wb_adr_in[7:6] == bdl_pkg::WIN_REGS);
    assign win_idx = wb_adr_in[5:2];
    assign take    = (q.st == bdl_pkg::ST_IDLE) && q.ctrl_en && instr_valid_in;

    // Next-state logic
    always_comb begin
        n = q;
        n.done = 1'b0;
        n.ack = bus_req;
        ev = '0;
        clr = '0;

        // Register access
        if (bus_req) begin
            n.rdata = '0;
            if (wb_we_in) begin
                if (is_win) begin
                    n.regs[win_idx] = bdl_pkg::lane_merge(q.regs[win_idx], wb_dat_in,
                                                          wb_sel_in);
                end else begin
                    case (wb_adr_in)
                        bdl_pkg::ADR_CLEAR: begin
                            if (wb_sel_in[0]) begin
                                clr = wb_dat_in[bdl_pkg::NEV-1:0];
                            end
                        end
                        bdl_pkg::ADR_ENABLE: begin
                            if (wb_sel_in[0]) begin
                                n.enable = wb_dat_in[bdl_pkg::NEV-1:0];
                            end
                        end
                        bdl_pkg::ADR_CTRL: begin
                            if (wb_sel_in[0]) begin
                                n.ctrl_en = wb_dat_in[0];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (is_win) begin
                n.rdata = q.regs[win_idx];
            end else begin
                case (wb_adr_in)
                    bdl_pkg::ADR_STATUS: n.rdata = {27'h0, q.status};
                    bdl_pkg::ADR_ENABLE: n.rdata = {27'h0, q.enable};
                    bdl_pkg::ADR_CTRL:   n.rdata = {31'h0, q.ctrl_en};
                    bdl_pkg::ADR_LASTAD: n.rdata = q.last_addr;
                    bdl_pkg::ADR_STATE:  n.rdata = {30'h0, q.st};
                    default:             n.rdata = '0;
                endcase
            end
        end

        // Execution
        case (q.st)
            bdl_pkg::ST_IDLE: begin
                if (take) begin
                    if (!cond_pass_in) begin
                        n.done = 1'b1;
                    end else begin
                        ev[bdl_pkg::EV_UNPRED] = dif.unpred;
                        case (dif.op)
                            bdl_pkg::OP_BYTE,
                            bdl_pkg::OP_UNPRIV,
                            bdl_pkg::OP_DUAL: begin
                                n.st = bdl_pkg::ST_ACC1;
                                n.addr = madr_v;
                                n.wb_val = oadr_v;
                                n.rt = dif.rt;
                                n.rt2 = dif.rt2;
                                n.rn = dif.rn;
                                n.wback = dif.wback;
                                n.dual = (dif.op == bdl_pkg::OP_DUAL);
                                n.unpriv = (dif.op == bdl_pkg::OP_UNPRIV);
                            end
                            bdl_pkg::OP_HINT: begin
                                n.done = 1'b1;
                            end
                            default: begin
                                ev[bdl_pkg::EV_USAGE] = 1'b1;
                                n.done = 1'b1;
                            end
                        endcase
                    end
                end
            end
            bdl_pkg::ST_ACC1,
            bdl_pkg::ST_ACC2: begin
                if (mem_ack_in) begin
                    n.last_addr = q.addr;
                    if (mem_prot_in || mem_err_in) begin
                        ev[bdl_pkg::EV_PROT] = mem_prot_in;
                        ev[bdl_pkg::EV_BUS] = !mem_prot_in;
                        n.st = bdl_pkg::ST_IDLE;
                        n.done = 1'b1;
                    end else if (q.st == bdl_pkg::ST_ACC1 && q.dual) begin
                        n.word1 = mem_rdata_in;
                        n.addr = q.addr + bdl_pkg::WORD_STEP;
                        n.st = bdl_pkg::ST_ACC2;
                    end else begin
                        if (q.dual) begin
                            n.regs[q.rt] = q.word1;
                            n.regs[q.rt2] = mem_rdata_in;
                        end else begin
                            n.regs[q.rt] = {24'h0, mem_rdata_in[7:0]};
                        end
                        if (q.wback) begin
                            n.regs[q.rn] = q.wb_val;
                        end
                        n.st = bdl_pkg::ST_IDLE;
                        n.done = 1'b1;
                    end
                end
            end
            default: begin
                n.st = bdl_pkg::ST_IDLE;
            end
        endcase

        ev[bdl_pkg::EV_DONE] = n.done;
        // Set wins over clear
        n.status = (q.status & ~clr) | ev;
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            q <= '0;
            q.st <= bdl_pkg::ST_IDLE;
            q.ctrl_en <= bdl_pkg::CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs
    assign wb_dat_out      = q.rdata;
    assign wb_ack_out      = q.ack;
    assign irq_out         = |(q.status & q.enable);
    assign instr_ready_out = (q.st == bdl_pkg::ST_IDLE) && q.ctrl_en;
    assign done_out        = q.done;
    assign mem_req_out     = (q.st != bdl_pkg::ST_IDLE);
    assign mem_addr_out    = q.addr;
    assign mem_size_out    = q.dual ? bdl_pkg::SIZE_WORD : bdl_pkg::SIZE_BYTE;
    assign mem_unpriv_out  = q.unpriv;
endmodule
`default_nettype wire

/* test/bdl_unit_asserts.sv */
/* Port checker for the load unit.
   Assumes one clock domain and a bind from the bench top. */
`default_nettype none
module bdl_unit_asserts (
    input wire logic        clock_in,
    input wire logic        srst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire logic        instr_valid_in,
    input wire logic        cond_pass_in,
    input wire logic        instr_ready_out,
    input wire logic        done_out,
    input wire logic        mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [1:0]  mem_size_out,
    input wire logic        mem_unpriv_out,
    input wire logic        mem_ack_in,
    input wire logic        mem_err_in,
    input wire logic        mem_prot_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] nack_q;
    logic       acc_ack;
    // Acks seen within the current access sequence
    always_ff @(posedge clock_in)
        nack_q <= (srst_in || !mem_req_out) ? 2'h0 : nack_q + 2'(mem_ack_in);
    assign acc_ack = mem_req_out && mem_ack_in;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);
    AST_WB_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not acknowledged in one cycle");
    AST_WB_ONE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus acknowledge longer than one cycle");
    AST_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
        && $stable(mem_addr_out) && $stable(mem_size_out) && $stable(mem_unpriv_out))
        else $error("access changed before its acknowledge");
    AST_UNPRIV: assert property (mem_req_out && mem_unpriv_out |->
        mem_size_out == bdl_pkg::SIZE_BYTE) else $error("unprivileged access not a byte");
    AST_BYTE_END: assert property (acc_ack && mem_size_out == bdl_pkg::SIZE_BYTE |=>
        done_out && !mem_req_out) else $error("byte load did not end after one access");
    AST_DUAL_NEXT: assert property (acc_ack && !mem_err_in && !mem_prot_in && nack_q == 2'h0
        && mem_size_out == bdl_pkg::SIZE_WORD |=> mem_req_out
        && mem_addr_out == $past(mem_addr_out) + bdl_pkg::WORD_STEP)
        else $error("second word not at the next word address");
    AST_DUAL_END: assert property (acc_ack && nack_q == 2'h1 |=> done_out && !mem_req_out)
        else $error("dual load did not end after two words");
    AST_COND: assert property (instr_valid_in && instr_ready_out && !cond_pass_in |=>
        done_out && !mem_req_out) else $error("failed condition still accessed memory");
endmodule
`default_nettype wire

/* test/bdl_mem_model.sv */
/* Memory model answering the unit's load accesses.
   Assumes a request holds until it is acknowledged. */
`default_nettype none
module bdl_mem_model (
    input  wire logic        clock_in,
    input  wire logic [1:0]  fault_in,
    input  wire logic        req_in,
    input  wire logic [31:0] addr_in,
    output logic      [31:0] rdata_out,
    output logic             ack_out,
    output logic             err_out,
    output logic             prot_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_q = 2'h0;
    // Quiet outputs from time zero
    initial begin
        rdata_out = 32'h0;
        ack_out = 1'b0;
        err_out = 1'b0;
        prot_out = 1'b0;
    end
    // Answer after zero to three cycles; data churns when not answering
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        err_out <= 1'b0;
        prot_out <= 1'b0;
        rdata_out <= rdata_out + 32'h9e37_79b9;
        if (req_in && !ack_out && wait_q == 2'h0) begin
            ack_out <= 1'b1;
            err_out <= fault_in == 2'h1;
            prot_out <= fault_in == 2'h2;
            rdata_out <= ~addr_in;
            wait_q <= 2'($urandom_range(3));
        end else if (req_in && !ack_out) begin
            wait_q <= wait_q - 2'h1;
        end
    end
endmodule
`default_nettype wire

/* test/bdl_unit_tb_top.sv */
/* Bench for the load unit: bus tasks, memory model, random loads.
   Assumes checker and memory model are compiled before it. */
`default_nettype none
module bdl_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MX [8] = '{32'h1f, 32'hfff, 32'hff, 32'h0,
                                       32'hff, 32'hfff, 32'h3fc, 32'h0};
    logic        clock_in = 1'b0, srst_in = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        valid = 1'b0, cond = 1'b1, wide = 1'b0, got, unp0;
    logic        ack, irq, ready, done, mreq, munp, mack, merr, mprot;
    logic [1:0]  msize, fault = 2'h0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wdat = 32'h0, instr = 32'h0, pc = 32'h0, rdat, maddr, mrd, a0;
    int          mismatches = 0, checked = 0;
    bdl_unit u_bdl_unit (.clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
        .instr_valid_in(valid), .instr_in(instr), .instr_wide_in(wide),
        .cond_pass_in(cond), .pc_in(pc), .instr_ready_out(ready), .done_out(done),
        .mem_req_out(mreq), .mem_addr_out(maddr), .mem_size_out(msize),
        .mem_unpriv_out(munp), .mem_rdata_in(mrd), .mem_ack_in(mack),
        .mem_err_in(merr), .mem_prot_in(mprot));
    bdl_mem_model u_bdl_mem_model (.clock_in(clock_in), .fault_in(fault), .req_in(mreq),
        .addr_in(maddr), .rdata_out(mrd), .ack_out(mack), .err_out(merr), .prot_out(mprot));
    // Core clock, 25 ns period
    initial forever #12.5 clock_in = ~clock_in;
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One clock edge with a bound on the wait
    task automatic tick(inout int n);
        @(posedge clock_in);
        n++;
        if (n > 300) begin
            check(32'h0, 32'h1);
            summarize();
        end
    endtask
    // One classic bus cycle; q takes the read data at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do tick(n); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        tick(n);
    endtask
    // Offer one instruction, note its first access, wait for done
    task automatic exec(input logic [31:0] i, input logic c);
        int n = 0;
        got = 1'b0;
        valid <= 1'b1;
        instr <= i;
        wide <= i[31:16] != 16'h0;
        cond <= c;
        do tick(n); while (ready !== 1'b1);
        valid <= 1'b0;
        do begin
            tick(n);
            if (mreq === 1'b1 && !got) begin
                got = 1'b1;
                a0 = maddr;
                unp0 = munp;
            end
        end while (done !== 1'b1);
    endtask
    // One random load of kind k; f picks the largest immediate offset
    task automatic load(input int k, input logic f);
        logic [31:0] i, b, m, im, off, ea, q;
        logic [3:0]  rn, rt, rm;
        logic [2:0]  puw;
        logic [1:0]  sh;
        rn = 4'($urandom_range(5));
        rt = rn + 4'h1;
        rm = rn + 4'h2;
        b = $urandom;
        m = $urandom;
        sh = k == 3 ? 2'($urandom) : 2'h0;
        puw = 3'($urandom);
        if (k != 2 && k != 6) puw = {1'b1, k != 5 || puw[1], 1'b0};
        puw[0] = puw[0] | ~puw[2];
        if (k == 2 && puw == 3'b110) puw = 3'b100;
        im = f ? MX[k] : $urandom & MX[k];
        if (k == 3 || k == 7) im = m << sh;
        if (k == 5) b = m & bdl_pkg::ALIGN_MASK;
        if (k == 6) b[1:0] = 2'h0;
        off = puw[1] ? b + im : b - im;
        ea = puw[2] ? off : b;
        case (k)
            0: i = {16'h0, 5'h0f, im[4:0], rn[2:0], rt[2:0]};
            1: i = {12'hf89, rn, rt, im[11:0]};
            2: i = {12'hf81, rn, rt, 1'b1, puw, im[7:0]};
            3: i = {12'hf81, rn, rt, 6'h00, sh, rm};
            4: i = {12'hf81, rn, rt, 4'he, im[7:0]};
            5: i = {8'hf8, puw[1], 7'h1f, rt, im[11:0]};
            6: i = {7'h74, puw[2:1], 1'b1, puw[0], 1'b1, rn, rt, rt + 4'h1, im[9:2]};
            default: i = {16'h0, 7'h2e, rm[2:0], rn[2:0], rt[2:0]};
        endcase
        wb(1'b1, {2'h1, rn, 2'h0}, b, q);
        wb(1'b1, {2'h1, rm, 2'h0}, m, q);
        wb(1'b1, {2'h1, rt, 2'h0}, 32'hffff_ffff, q);
        pc <= m;
        exec(i, 1'b1);
        check(a0, ea);
        check(32'(unp0), 32'(k == 4));
        wb(1'b0, {2'h1, rt, 2'h0}, 32'h0, q);
        check(q, k == 6 ? ~ea : {24'h0, ~ea[7:0]});
        wb(1'b0, {2'h1, rn, 2'h0}, 32'h0, q);
        check(q, puw[0] ? off : b);
        wb(1'b0, bdl_pkg::ADR_LASTAD, 32'h0, q);
        check(q, k == 6 ? ea + 32'h4 : ea);
        if (k == 6) begin
            wb(1'b0, {2'h1, rt + 4'h1, 2'h0}, 32'h0, q);
            check(q, ~(ea + 32'h4));
        end
    endtask
    // Run one instruction, then compare the masked status
    task automatic flag(input logic [31:0] i, input logic [31:0] mk, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b1, bdl_pkg::ADR_CLEAR, 32'h1f, q);
        exec(i, 1'b1);
        wb(1'b0, bdl_pkg::ADR_STATUS, 32'h0, q);
        check(q & mk, e);
    endtask
    // Main sequence
    initial begin
        logic [31:0] q, e;
        void'($urandom(32'hb040));
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        wb(1'b0, bdl_pkg::ADR_CTRL, 32'h0, q);
        check(q, 32'h1);
        wb(1'b0, bdl_pkg::ADR_ENABLE, 32'h0, q);
        check(q, 32'h0);
        wb(1'b0, bdl_pkg::ADR_STATE, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, 8'h20, 32'hffff_ffff, q);
        wb(1'b0, 8'h20, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, bdl_pkg::ADR_CTRL, 32'h0, q);
        check(32'(ready), 32'h0);
        wb(1'b1, bdl_pkg::ADR_CTRL, 32'h1, q);
        $display("registers test ended");
        for (int k = 0; k < 8; k++)
            for (int j = 0; j < 6; j++)
                load(k, j == 0);
        $display("random load test ended");
        flag(32'he9d1_2201, 32'h10, 32'h10);
        flag(32'he9d1_d201, 32'h10, 32'h10);
        flag(32'he9f1_1201, 32'h10, 32'h10);
        flag(32'he8d1_2301, 32'h08, 32'h08);
        flag(32'he9df_2301, 32'h08, 32'h08);
        flag(32'hf891_d004, 32'h10, 32'h10);
        flag(32'hf891_2004, 32'h18, 32'h00);
        flag(32'hf811_fe04, 32'h10, 32'h10);
        flag(32'hf811_2a04, 32'h08, 32'h08);
        flag(32'hf891_f004, 32'h1f, 32'h01);
        check(32'(got), 32'h0);
        flag(32'hf81f_2003, 32'h08, 32'h00);
        check(a0, (pc & bdl_pkg::ALIGN_MASK) - 32'h3);
        wb(1'b1, 8'h48, 32'h5a, q);
        exec(32'hf891_2004, 1'b0);
        check(32'(got), 32'h0);
        wb(1'b0, 8'h48, 32'h0, q);
        check(q, 32'h5a);
        $display("decode test ended");
        for (int f = 1; f < 3; f++) begin
            e = f == 1 ? 32'h4 : 32'h2;
            wb(1'b1, bdl_pkg::ADR_CLEAR, 32'h1f, q);
            wb(1'b1, bdl_pkg::ADR_ENABLE, e, q);
            fault <= 2'(f);
            exec(32'hf891_2004, 1'b1);
            fault <= 2'h0;
            check(32'(irq), 32'h1);
            wb(1'b0, 8'h48, 32'h0, q);
            check(q, 32'h5a);
            wb(1'b1, bdl_pkg::ADR_ENABLE, 32'h0, q);
            check(32'(irq), 32'h0);
            wb(1'b1, bdl_pkg::ADR_ENABLE, e, q);
            check(32'(irq), 32'h1);
            wb(1'b1, bdl_pkg::ADR_CLEAR, e, q);
            check(32'(irq), 32'h0);
        end
        $display("fault test ended");
        summarize();
    end
endmodule
bind bdl_unit bdl_unit_asserts u_bdl_unit_asserts (.clock_in, .srst_in, .wb_cyc_in,
    .wb_stb_in, .wb_ack_out, .instr_valid_in, .cond_pass_in, .instr_ready_out, .done_out,
    .mem_req_out, .mem_addr_out, .mem_size_out, .mem_unpriv_out, .mem_ack_in,
    .mem_err_in, .mem_prot_in);
`default_nettype wire
